/* File: pkg/fsp_pkg.sv */
/*
 * Shared constants and types of the flash self-programming controller and its CPU end.
 * Assumes one 50 MHz clock and a synchronous active-high reset on both ends.
 */
// Operation
// - Page must be erased before page write.
// - Erase pattern then store within four cycles.
// - Erasing upper section page halts the CPU.
// - Load pattern plus store writes buffer word.
// - Buffer clears after write, re-enable, reset.
// - Each buffer word loaded once per clear.
// - EEPROM write discards loaded buffer data.
// - Write pattern then store; low pointer bits zero.
// - Writing upper section page halts the CPU.
// - Interrupt level while enabled and enable clear.
// - Lower section reads blocked during erase, write.
// - Busy flag holds until re-enable bit written.
// - Store programs lock bits where data bit zero.
// - Lock programming ignores pointer, flash stays readable.
// - EEPROM write blocks programming and fuse reads.
// - Pointer one plus load reads lock byte.
// - Lock select bits clear on read or timeout.
// - Pointers zero, three, two read fuse bytes.
// - Programmed bits read zero, unprogrammed read one.
// - Signature bit plus load reads signature byte.
// - Identity bytes at zero, two, four; calibration one.
// - Signature bits clear on read or timeout.
// - Timed operations last the minimum programming time.
package fsp_pkg;
   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS    = 20;
   localparam int unsigned PROG_TIME_MIN_US = 3700;
   localparam int unsigned PROG_TIME_MAX_US = 4500;
   localparam int unsigned PROG_CYCLES_MIN  =
      (PROG_TIME_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  SPM_WINDOW       = 3'h4;
   localparam logic [2:0]  LPM_WINDOW       = 3'h3;

   // -------------------------------------------------------------------
   // Control and status register
   // -------------------------------------------------------------------
   localparam int unsigned CSR_EN   = 0;
   localparam int unsigned CSR_BUSY = 6;
   localparam int unsigned CSR_IE   = 7;
   localparam logic [5:0]  CMD_NONE  = 6'h00;
   localparam logic [5:0]  CMD_LOAD  = 6'h01;
   localparam logic [5:0]  CMD_ERASE = 6'h03;
   localparam logic [5:0]  CMD_WRITE = 6'h05;
   localparam logic [5:0]  CMD_LOCK  = 6'h09;
   localparam logic [5:0]  CMD_REEN  = 6'h11;
   localparam logic [5:0]  CMD_SIG   = 6'h21;

   // -------------------------------------------------------------------
   // Pointer layout and special addresses
   // -------------------------------------------------------------------
   localparam int unsigned PTR_W          = 16;
   localparam int unsigned DEF_PAGE_WORDS = 128;
   localparam int unsigned DEF_RWW_PAGES  = 224;
   localparam logic [15:0] PTR_FUSE_LOW   = 16'h0000;
   localparam logic [15:0] PTR_LOCK       = 16'h0001;
   localparam logic [15:0] PTR_FUSE_EXT   = 16'h0002;
   localparam logic [15:0] PTR_FUSE_HIGH  = 16'h0003;
   localparam logic [15:0] SIG_ADDR_ID0   = 16'h0000;
   localparam logic [15:0] SIG_ADDR_CAL   = 16'h0001;
   localparam logic [15:0] SIG_ADDR_ID1   = 16'h0002;
   localparam logic [15:0] SIG_ADDR_ID2   = 16'h0004;
   localparam logic [5:0]  LOCK_RESET     = 6'h3F;
   localparam logic [1:0]  LOCK_PAD       = 2'h3;
   localparam logic [7:0]  SIG_RESERVED   = 8'hFF;
   localparam logic [15:0] BUF_ERASED     = 16'hFFFF;

   // -------------------------------------------------------------------
   // Host command port offsets
   // -------------------------------------------------------------------
   localparam logic [2:0] HOST_CTRL   = 3'h0;
   localparam logic [2:0] HOST_PTR    = 3'h1;
   localparam logic [2:0] HOST_DATA   = 3'h2;
   localparam logic [2:0] HOST_ISSUE  = 3'h3;
   localparam logic [2:0] HOST_RESULT = 3'h4;
   localparam logic [2:0] HOST_EE     = 3'h5;

   typedef enum logic [1:0] {FSP_OP_ERASE, FSP_OP_WRITE, FSP_OP_LOCK} fsp_op_t;
   typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_PROG} fsp_state_t;
endpackage : fsp_pkg

/* File: pkg/fsp_if.sv */
/*
 * Link between the CPU end and the self-programming controller.
 * Assumes both ends run on the same clock; all signals are plain levels or one-cycle pulses.
 */
`timescale 1ns/10ps
interface fsp_if;
   logic        csr_wr;
   logic [7:0]  csr_wdata;
   logic [7:0]  csr_rdata;
   logic        store_instr;
   logic        load_instr;
   logic [15:0] ptr;
   logic [15:0] data_pair;
   logic        eeprom_busy;
   logic        eeprom_write_start;
   logic [7:0]  load_data;
   logic        load_valid;
   logic        spm_irq;
   logic        cpu_halt;
   logic        rww_block;

   modport dev (input csr_wr, csr_wdata, store_instr, load_instr, ptr, data_pair,
                input eeprom_busy, eeprom_write_start,
                output csr_rdata, load_data, load_valid, spm_irq, cpu_halt, rww_block);
   modport host (output csr_wr, csr_wdata, store_instr, load_instr, ptr, data_pair,
                 output eeprom_busy, eeprom_write_start,
                 input csr_rdata, load_data, load_valid, spm_irq, cpu_halt, rww_block);
endinterface : fsp_if

/* File: logic/fsp_device.sv */
/*
 * Flash self-programming controller: command windows, temporary page buffer,
 * timed erase/write/lock operations, fuse, lock and signature reads.
 * Assumes the CPU end pulses store and load for one cycle and holds pointer and data meanwhile.
 */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
module fsp_device
   import fsp_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES_MIN,
   parameter int unsigned PAGE_WORDS  = fsp_pkg::DEF_PAGE_WORDS,
   parameter int unsigned RWW_PAGES   = fsp_pkg::DEF_RWW_PAGES,
   parameter logic [7:0]  SIG_ID0     = 8'h11,   // Arbitrary identity value.
   parameter logic [7:0]  SIG_ID1     = 8'h22,   // Arbitrary identity value.
   parameter logic [7:0]  SIG_ID2     = 8'h33    // Arbitrary identity value.
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         srst,
   // CPU link
   fsp_if.dev                bus,
   // Fuse and calibration values
   input  wire logic [7:0]   fuse_low,
   input  wire logic [7:0]   fuse_high,
   input  wire logic [7:0]   fuse_ext,
   input  wire logic [7:0]   cal_byte,
   // Flash array side
   input  wire logic [$clog2(PAGE_WORDS)-1:0] buf_rd_idx,
   output logic      [15:0]  buf_rd_data,
   output logic      [5:0]   lock_bits,
   output logic              prog_start,
   output logic              prog_done,
   output fsp_pkg::fsp_op_t  prog_kind,
   output logic      [fsp_pkg::PTR_W-$clog2(PAGE_WORDS)-2:0] prog_page
);
   import fsp_pkg::*;

   // -------------------------------------------------------------------
   // Geometry and parameter checks
   // -------------------------------------------------------------------
   localparam int unsigned WB = $clog2(PAGE_WORDS);
   localparam int unsigned PG = PTR_W - WB - 1;
   localparam int unsigned TW = $clog2(PROG_CYCLES + 1);

   if ((PAGE_WORDS != (1 << WB)) || (WB < 1) || (PG < 1)) begin : g_bad_page
      $error("PAGE_WORDS must be a power of two that fits the pointer.");
   end
   if ((RWW_PAGES < 1) || (RWW_PAGES > (1 << PG)) || (PROG_CYCLES < 1)) begin : g_bad_cnt
      $error("RWW_PAGES or PROG_CYCLES out of range.");
   end

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   fsp_state_t          state;
   logic [5:0]          cmd;
   logic                ie;
   logic                rww_busy;
   logic [2:0]          spm_cnt;
   logic [2:0]          lpm_cnt;
   logic [TW-1:0]       timer;
   logic [5:0]          lock_new;
   logic [15:0]         buf_mem [PAGE_WORDS];
   logic                buf_vld [PAGE_WORDS];

   // -------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------
   wire          is_idle   = (state == FSP_IDLE);
   wire          is_armed  = (state == FSP_ARMED);
   wire          is_prog   = (state == FSP_PROG);
   wire          csr_take  = bus.csr_wr && is_idle && !bus.eeprom_busy
                             && bus.csr_wdata[CSR_EN];
   wire          spm_hit   = bus.store_instr && is_armed && !bus.eeprom_busy;
   wire          lpm_hit   = bus.load_instr && is_armed && !bus.eeprom_busy
                             && (lpm_cnt != 3'h0)
                             && ((cmd == CMD_LOCK) || (cmd == CMD_SIG));
   wire          spm_last  = is_armed && (spm_cnt == 3'h1);
   wire          lpm_last  = is_armed && (lpm_cnt == 3'h1) && (cmd == CMD_SIG);
   wire [WB-1:0] word_idx  = bus.ptr[WB:1];
   wire [PG-1:0] page_sel  = bus.ptr[PTR_W-1:WB+1];
   wire          buf_wr    = spm_hit && (cmd == CMD_LOAD);
   wire          start_ers = spm_hit && (cmd == CMD_ERASE);
   wire          start_wrt = spm_hit && (cmd == CMD_WRITE);
   wire          start_lck = spm_hit && (cmd == CMD_LOCK);
   wire          reen_hit  = spm_hit && (cmd == CMD_REEN);
   wire          op_start  = start_ers || start_wrt || start_lck;
   wire          op_done   = is_prog && (timer == TW'(1));
   wire          done_wrt  = op_done && (prog_kind == FSP_OP_WRITE);
   wire          buf_clr   = done_wrt || reen_hit || bus.eeprom_write_start;
   wire          upper_pg  = (prog_page >= PG'(RWW_PAGES));
   wire          flash_op  = is_prog && (prog_kind != FSP_OP_LOCK);

   // Fuse and lock answers pick by the whole pointer value; lock pads read as unprogrammed.
   wire [7:0] fuse_val  = (bus.ptr == PTR_FUSE_LOW)  ? fuse_low
                        : (bus.ptr == PTR_LOCK)      ? {LOCK_PAD, lock_bits}
                        : (bus.ptr == PTR_FUSE_EXT)  ? fuse_ext
                        : (bus.ptr == PTR_FUSE_HIGH) ? fuse_high
                        : SIG_RESERVED;
   wire [7:0] sig_val   = (bus.ptr == SIG_ADDR_ID0) ? SIG_ID0
                        : (bus.ptr == SIG_ADDR_CAL) ? cal_byte
                        : (bus.ptr == SIG_ADDR_ID1) ? SIG_ID1
                        : (bus.ptr == SIG_ADDR_ID2) ? SIG_ID2
                        : SIG_RESERVED;
   wire       next_ie_w   = bus.csr_wr ? bus.csr_wdata[CSR_IE] : ie;
   wire       next_busy_w = (rww_busy || start_ers || start_wrt) && !reen_hit;
   wire [5:0] next_cmd_w  = csr_take ? bus.csr_wdata[5:0] : cmd;
   // A store in the last window cycle that starts an operation keeps the enable bit up.
   wire       arm_end   = is_armed && !op_start
                          && (lpm_hit || spm_hit || spm_last || lpm_last);
   wire       next_en   = !(is_idle && !csr_take) && !arm_end && !op_done;
   wire [7:0] next_csr  = {next_ie_w, next_busy_w, (next_en ? next_cmd_w[5:1] : 5'h00),
                           next_en};

   // -------------------------------------------------------------------
   // Command sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= FSP_IDLE;
         cmd   <= CMD_NONE;
         spm_cnt <= 3'h0;
         lpm_cnt <= 3'h0;
      end else begin
         case (state)
            FSP_IDLE: begin
               if (csr_take) begin
                  state   <= FSP_ARMED;
                  cmd     <= bus.csr_wdata[5:0];
                  spm_cnt <= SPM_WINDOW;
                  lpm_cnt <= LPM_WINDOW;
               end
            end
            FSP_ARMED: begin
               spm_cnt <= spm_cnt - 3'h1;
               lpm_cnt <= (lpm_cnt == 3'h0) ? 3'h0 : lpm_cnt - 3'h1;
               if (op_start) begin
                  state <= FSP_PROG;
               end else if (spm_hit || lpm_hit || spm_last || lpm_last) begin
                  state <= FSP_IDLE;
                  cmd   <= CMD_NONE;
               end
            end
            FSP_PROG: begin
               if (op_done) begin
                  state <= FSP_IDLE;
                  cmd   <= CMD_NONE;
               end
            end
            default: begin
               state <= FSP_IDLE;
               cmd   <= CMD_NONE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Timed operation
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         timer      <= '0;
         prog_kind  <= FSP_OP_ERASE;
         prog_page  <= '0;
         lock_new   <= LOCK_RESET;
         lock_bits  <= LOCK_RESET;
         prog_start <= 1'b0;
         prog_done  <= 1'b0;
      end else begin
         prog_start <= op_start;
         prog_done  <= op_done;
         if (op_start) begin
            timer     <= TW'(PROG_CYCLES);
            prog_kind <= start_ers ? FSP_OP_ERASE : start_wrt ? FSP_OP_WRITE : FSP_OP_LOCK;
            prog_page <= page_sel;
            lock_new  <= bus.data_pair[5:0];
         end else if (is_prog) begin
            timer <= timer - TW'(1);
         end
         if (op_done && (prog_kind == FSP_OP_LOCK)) begin
            lock_bits <= lock_bits & lock_new;
         end
      end
   end

   // -------------------------------------------------------------------
   // Status, interrupt and read answers
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ie             <= 1'b0;
         rww_busy       <= 1'b0;
         bus.csr_rdata  <= 8'h00;
         bus.load_data  <= 8'h00;
         bus.load_valid <= 1'b0;
         bus.spm_irq    <= 1'b0;
         bus.cpu_halt   <= 1'b0;
         bus.rww_block  <= 1'b0;
      end else begin
         ie             <= next_ie_w;
         rww_busy       <= next_busy_w;
         bus.csr_rdata  <= next_csr;
         bus.load_valid <= lpm_hit;
         bus.load_data  <= (cmd == CMD_SIG) ? sig_val : fuse_val;
         bus.spm_irq    <= next_ie_w && !next_en;
         bus.cpu_halt   <= flash_op && upper_pg && !op_done;
         bus.rww_block  <= flash_op && !op_done;
      end
   end

   // -------------------------------------------------------------------
   // Temporary page buffer
   // -------------------------------------------------------------------
   for (genvar gi = 0; gi < PAGE_WORDS; gi++) begin : g_buf
      always_ff @(posedge clk) begin
         if (srst || buf_clr) begin
            buf_mem[gi] <= BUF_ERASED;
            buf_vld[gi] <= 1'b0;
         end else if (buf_wr && (word_idx == WB'(gi))) begin
            buf_mem[gi] <= bus.data_pair;
            buf_vld[gi] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         buf_rd_data <= BUF_ERASED;
      end else begin
         buf_rd_data <= buf_vld[buf_rd_idx] ? buf_mem[buf_rd_idx] : BUF_ERASED;
      end
   end
endmodule : fsp_device

/* File: logic/fsp_host.sv */
/*
 * CPU end of the self-programming link: turns a plain software port into
 * control writes, store and load pulses, and guards buffer and erase order.
 * Assumes software writes the control word and then the issue register back to back.
 */
`timescale 1ns/10ps
module fsp_host
   import fsp_pkg::*;
#(
   parameter int unsigned PAGE_WORDS = fsp_pkg::DEF_PAGE_WORDS
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Device link
   fsp_if.host              bus,
   // Software port
   input  wire logic [2:0]  sw_addr,
   input  wire logic [15:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [15:0] sw_rdata
);
   import fsp_pkg::*;

   localparam int unsigned WB = $clog2(PAGE_WORDS);
   localparam int unsigned PG = PTR_W - WB - 1;

   if ((PAGE_WORDS != (1 << WB)) || (WB < 1) || (PG < 1)) begin : g_bad_page
      $error("PAGE_WORDS must be a power of two that fits the pointer.");
   end

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [5:0]            last_cmd;
   logic [PAGE_WORDS-1:0] loaded;
   logic [PG-1:0]         erased_page;
   logic                  erased_ok;
   logic [7:0]            result;
   logic                  result_vld;
   logic                  err;

   // -------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------
   wire          wr_ctrl   = sw_wr && (sw_addr == HOST_CTRL);
   wire          wr_issue  = sw_wr && (sw_addr == HOST_ISSUE) && !bus.cpu_halt;
   wire [WB-1:0] word_idx  = bus.ptr[WB:1];
   wire [PG-1:0] page_sel  = bus.ptr[PTR_W-1:WB+1];
   wire          dup_load  = (last_cmd == CMD_LOAD) && loaded[word_idx];
   wire          bad_write = (last_cmd == CMD_WRITE) && (!erased_ok
                             || (erased_page != page_sel)
                             || (bus.ptr[WB:0] != '0));
   wire          want_st   = wr_issue && sw_wdata[0];
   wire          store_ok  = want_st && !dup_load && !bad_write;
   wire          load_go   = wr_issue && sw_wdata[1];
   wire          clr_mask  = (store_ok && ((last_cmd == CMD_WRITE) || (last_cmd == CMD_REEN)))
                             || bus.eeprom_write_start;

   // -------------------------------------------------------------------
   // Link drive
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.csr_wr             <= 1'b0;
         bus.csr_wdata          <= 8'h00;
         bus.store_instr        <= 1'b0;
         bus.load_instr         <= 1'b0;
         bus.ptr                <= 16'h0000;
         bus.data_pair          <= 16'h0000;
         bus.eeprom_busy        <= 1'b0;
         bus.eeprom_write_start <= 1'b0;
      end else begin
         bus.csr_wr             <= wr_ctrl;
         bus.store_instr        <= store_ok;
         bus.load_instr         <= load_go;
         bus.eeprom_write_start <= sw_wr && (sw_addr == HOST_EE) && sw_wdata[0];
         if (wr_ctrl) begin
            bus.csr_wdata <= sw_wdata[7:0];
         end
         if (sw_wr && (sw_addr == HOST_PTR)) begin
            bus.ptr <= sw_wdata;
         end
         if (sw_wr && (sw_addr == HOST_DATA)) begin
            bus.data_pair <= sw_wdata;
         end
         if (sw_wr && (sw_addr == HOST_EE)) begin
            bus.eeprom_busy <= sw_wdata[1];
         end
      end
   end

   // -------------------------------------------------------------------
   // Order guards, results and software reads
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         last_cmd    <= CMD_NONE;
         loaded      <= '0;
         erased_page <= '0;
         erased_ok   <= 1'b0;
         result      <= 8'h00;
         result_vld  <= 1'b0;
         err         <= 1'b0;
         sw_rdata    <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            last_cmd <= sw_wdata[5:0];
         end
         if (clr_mask) begin
            loaded <= '0;
         end else if (store_ok && (last_cmd == CMD_LOAD)) begin
            loaded[word_idx] <= 1'b1;
         end
         if (store_ok && (last_cmd == CMD_ERASE)) begin
            erased_page <= page_sel;
            erased_ok   <= 1'b1;
         end else if (store_ok && (last_cmd == CMD_WRITE)) begin
            erased_ok <= 1'b0;
         end
         if (bus.load_valid) begin
            result     <= bus.load_data;
            result_vld <= 1'b1;
         end else if (load_go) begin
            result_vld <= 1'b0;
         end
         if (want_st && !store_ok) begin
            err <= 1'b1;
         end else if (sw_rd && (sw_addr == HOST_RESULT)) begin
            err <= 1'b0;
         end
         if (sw_rd) begin
            case (sw_addr)
               HOST_CTRL:   sw_rdata <= {5'h00, bus.rww_block, bus.cpu_halt, bus.spm_irq,
                                         bus.csr_rdata};
               HOST_PTR:    sw_rdata <= bus.ptr;
               HOST_DATA:   sw_rdata <= bus.data_pair;
               HOST_RESULT: sw_rdata <= {6'h00, err, result_vld, result};
               HOST_EE:     sw_rdata <= {14'h0000, bus.eeprom_busy, 1'b0};
               default:     sw_rdata <= 16'h0000;
            endcase
         end else begin
            sw_rdata <= 16'h0000;
         end
      end
   end
endmodule : fsp_host

/* File: bench/fsp_link_monitor.sv */
/* Checker of the link between the CPU end and the controller.
   Assumes one clock, synchronous reset and a programming timer of 8 cycles. */
`timescale 1ns/10ps
module fsp_link_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // Link
   input wire logic        csr_wr,
   input wire logic [7:0]  csr_wdata,
   input wire logic [7:0]  csr_rdata,
   input wire logic        store_instr,
   input wire logic        load_instr,
   input wire logic [15:0] ptr,
   input wire logic [7:0]  load_data,
   input wire logic        load_valid,
   input wire logic        spm_irq,
   input wire logic        rww_block
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_load_answer: assert property (load_valid |-> $past(load_instr))
      else $error("load answer without load");
   a_block_cause: assert property ($rose(rww_block) |-> $past(store_instr, 2))
      else $error("block without store");
   a_busy_release: assert property (
      $fell(csr_rdata[6]) |-> $past(store_instr) || $past(store_instr, 2))
      else $error("busy flag fell without store");
   a_irq_level: assert property ((csr_rdata[7] && !csr_rdata[0]) [*2] |-> spm_irq)
      else $error("interrupt level missing");
   a_lock_readable: assert property (
      store_instr && $past(csr_wr) && $past(csr_wdata[5:0]) == 6'h09 |=> !rww_block [*4])
      else $error("lock write blocked reads");
   a_erase_holds: assert property (
      store_instr && $past(csr_wr) && $past(csr_wdata[5:0]) == 6'h03 |=> ##1 rww_block [*7])
      else $error("erase block too short");
   a_window_close: assert property (
      csr_wr && csr_wdata[0] && !csr_rdata[0] ##1 (!store_instr && !load_instr) [*4]
      |-> ##[1:2] !csr_rdata[0])
      else $error("enable stayed after window");
   a_sig_reserved: assert property (
      load_instr && $past(csr_wr) && $past(csr_wdata[5:0]) == 6'h21 && ptr == 16'h0003
      |=> load_valid && load_data == 8'hFF)
      else $error("reserved signature not 0xFF");
endmodule : fsp_link_monitor

/* File: bench/tb_top.sv */
/* Bench joining both ends through the link interface.
   Assumes a programming timer shortened to 8 cycles. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
   import fsp_pkg::*;
   logic        clk = 0, srst = 1, sw_wr = 0, sw_rd = 0;
   logic [2:0]  sw_addr = 0;
   logic [15:0] sw_wdata = 0, sw_rdata, buf_rd_data;
   logic [5:0]  lock_bits;
   logic [7:0]  prog_page;
   logic        prog_start, prog_done;
   fsp_op_t     prog_kind;
   logic [7:0]  fx [4] = '{8'h5A, 8'hC3, 8'h3C, 8'hA5};
   logic [7:0]  sx [5] = '{8'h11, 8'h96, 8'h22, 8'hFF, 8'h33};
   int          errors = 0, cmp_count = 0, cyc = 0, n_start = 0, n_done = 0;
   fsp_if bus_if ();
   fsp_host fsp_host_inst (.clk(clk), .srst(srst), .bus(bus_if), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   fsp_device #(.PROG_CYCLES(8)) fsp_device_inst (.clk(clk), .srst(srst), .bus(bus_if),
      .fuse_low(fx[0]), .fuse_high(fx[3]), .fuse_ext(fx[2]), .cal_byte(sx[1]),
      .buf_rd_idx(7'h02), .buf_rd_data(buf_rd_data), .lock_bits(lock_bits),
      .prog_start(prog_start), .prog_done(prog_done), .prog_kind(prog_kind), .prog_page(prog_page));
   fsp_link_monitor fsp_link_monitor_inst (.clk(clk), .srst(srst), .csr_wr(bus_if.csr_wr),
      .csr_wdata(bus_if.csr_wdata), .csr_rdata(bus_if.csr_rdata),
      .store_instr(bus_if.store_instr), .load_instr(bus_if.load_instr), .ptr(bus_if.ptr),
      .load_data(bus_if.load_data), .load_valid(bus_if.load_valid),
      .spm_irq(bus_if.spm_irq), .rww_block(bus_if.rww_block));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (prog_start === 1'b1) n_start++;
      if (prog_done === 1'b1) n_done++;
      if (cyc == 3000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      sw_addr  <= a;
      sw_wdata <= d;
      sw_wr    <= 1'b1;
      @(posedge clk);
   endtask : wr
   task automatic idle(input int n);
      sw_wr <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      sw_wr   <= 1'b0;
      sw_addr <= a;
      sw_rd   <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 `CHK("sw_rdata", e, sw_rdata)
      @(posedge clk);
   endtask : rd
   // Pointer, data, then control and issue back to back.
   task automatic op(input logic [15:0] p, d, c, iss, input int n);
      wr(3'h1, p);
      wr(3'h2, d);
      wr(3'h0, c);
      wr(3'h3, iss);
      idle(n);
   endtask : op
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1 `CHK("lock_bits", 6'h3F, lock_bits)
      `CHK("buf", 16'hFFFF, buf_rd_data)
      op(16'h0104, 16'hABCD, 16'h0001, 16'h0001, 3);
      #1 `CHK("buf", 16'hABCD, buf_rd_data)
      wr(3'h5, 16'h0001);
      idle(2);
      #1 `CHK("buf", 16'hFFFF, buf_rd_data)
      op(16'h0104, 16'h1234, 16'h0001, 16'h0001, 1);
      op(16'h0104, 16'h5555, 16'h0001, 16'h0001, 4);
      #1 `CHK("buf", 16'h1234, buf_rd_data)
      rd(3'h4, 16'h0200);
      op(16'h0100, 16'h0000, 16'h0003, 16'h0001, 3);
      rd(3'h0, 16'h0443);
      idle(10);
      rd(3'h0, 16'h0040);
      op(16'h0100, 16'h0000, 16'h0005, 16'h0001, 12);
      #1 `CHK("buf", 16'hFFFF, buf_rd_data)
      op(16'h0100, 16'h0000, 16'h0005, 16'h0001, 4);
      rd(3'h4, 16'h0200);
      op(16'h0000, 16'h0000, 16'h0011, 16'h0001, 3);
      rd(3'h0, 16'h0000);
      op(16'h0001, 16'h00C3, 16'h0009, 16'h0001, 12);
      #1 `CHK("lock_bits", 6'h03, lock_bits)
      `CHK("prog_kind", FSP_OP_LOCK, prog_kind)
      for (int i = 0; i < 4; i++) begin
         op(16'(i), 16'h0000, 16'h0009, 16'h0002, 3);
         rd(3'h4, {8'h01, fx[i]});
      end
      for (int i = 0; i < 5; i++) begin
         op(16'(i), 16'h0000, 16'h0021, 16'h0002, 3);
         rd(3'h4, {8'h01, sx[i]});
      end
      for (int i = 0; i < 2; i++) begin
         wr(3'h0, (i == 0) ? 16'h0009 : 16'h0021);
         idle(8);
         rd(3'h0, 16'h0000);
      end
      wr(3'h0, 16'h0080);
      idle(2);
      rd(3'h0, 16'h0180);
      wr(3'h0, 16'h0000);
      op(16'hE000, 16'h0000, 16'h0003, 16'h0001, 3);
      rd(3'h0, 16'h0643);
      #1 `CHK("prog_page", 8'hE0, prog_page)
      idle(10);
      op(16'h0000, 16'h0000, 16'h0011, 16'h0001, 3);
      wr(3'h5, 16'h0002);
      op(16'h0000, 16'h0000, 16'h0009, 16'h0002, 3);
      rd(3'h0, 16'h0000);
      rd(3'h4, 16'h0033);
      wr(3'h5, 16'h0000);
      idle(2);
      `CHK("prog_start", 4, n_start)
      `CHK("prog_done", 4, n_done)
      stop_test();
   end
endmodule : tb_top
